// ==== hdl/event_reg_bank.sv ====
`timescale 1ns/1ps
`include "status_event_defs.svh"
module event_reg_bank (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] rd_index_i,
	input wire status_event_pkg::event_regs_t regs_i,
	input wire logic [2:0] temp_code_i,
	output logic [31:0] rd_data_o
);
	typedef struct packed {
		logic [31:0] rdata;
	} bank_state_t;
	bank_state_t st_ff;
	bank_state_t nxt_st;
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = 32'h0000_0000;
		unique case (rd_index_i)
			`REG_STAT08: nxt_st.rdata[`BIT_CRIT] = regs_i.crit;
			`REG_STAT09: nxt_st.rdata[7:0] = regs_i.st09;
			`REG_STAT0A: nxt_st.rdata[7:0] = regs_i.st0a;
			`REG_MASK16: nxt_st.rdata[7:0] = regs_i.mask16;
			`REG_MASK17: nxt_st.rdata[7:0] = regs_i.mask17;
			`REG_TCFG1B: nxt_st.rdata[7:0] = regs_i.tcfg1b;
			`REG_CRIT2E: nxt_st.rdata[7:0] = regs_i.crit2e;
			`REG_MCFG2F: nxt_st.rdata[7:0] = regs_i.mcfg2f;
			`REG_TEMP_NOW: nxt_st.rdata[2:0] = temp_code_i;
			default: nxt_st.rdata = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign rd_data_o = st_ff.rdata;
endmodule // event_reg_bank

// ==== hdl/status_event_interrupt_logic.sv ====
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "status_event_defs.svh"
// Notes on behaviour
// - buck_c high current/power sets 0x09[0], cleared by 0x11[0], masked by 0x16[0], irq only, rails stay ok.
// - temperature at or above 0x1B[2:0] sets 0x09[7], clear 0x11[7], mask 0x16[7], irq only.
// - temperature at or above 0x2E[2:0] sets 0x08[6], unmaskable, requests shutdown, drops rails ok and irq.
// - a bus packet check failure sets 0x0A[3], clear 0x12[3], mask 0x17[3], irq only.
// - a bus parity error sets 0x0A[2], clear 0x12[2], mask 0x17[2], irq only.
// - an asserted output holds until the host clears or masks its bit; here critical 0x08[6] has no clear path and holds until rst_i.
// - with masks zero an event drives the irq line low.
// - after a clear with the event gone and masks zero the irq line is released.
// - with masks set and 0x2F[1:0] at 00 an event leaves the irq line released.
// - the irq output is off after reset until software writes 0x1B[3] to one.
// - the irq pin is open drain active low, only ever pulled low.
module status_event_interrupt_logic (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hsel,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic buck_c_high_current_i,
	input wire logic [2:0] temp_code_i,
	input wire logic pec_error_i,
	input wire logic parity_error_i,
	output logic general_status_irq_line_o,
	output logic general_status_irq_line_oe_o,
	output logic rails_ok_output_o,
	output logic regulator_shutdown_request_o
);
	typedef struct packed {
		status_event_pkg::event_regs_t regs;
		status_event_pkg::bus_phase_t phase;
		logic wr;
		logic [7:0] idx;
		logic irq_oe;
		logic rails_ok;
		logic shut;
		logic ready;
		logic err;
		logic pin;
	} top_state_t;

	top_state_t st_ff;
	top_state_t nxt_st;
	logic [31:0] rd_data;

	function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
		// set beats clear in the same cycle
		sticky = (cur & ~clr) | set;
	endfunction

	function automatic logic at_or_above(input logic [2:0] code, input logic [2:0] limit);
		// codes rise with temperature, so a plain compare is the threshold
		at_or_above = code >= limit;
	endfunction

	function automatic logic masked_reach_line(input logic [1:0] mode);
		// only mode 00 keeps masked events off the line
		masked_reach_line = mode != 2'b00;
	endfunction

	function automatic logic [7:0] pending(input logic [7:0] stat, input logic [7:0] mask, input logic pass_masked);
		if (pass_masked) begin
			pending = stat;
		end else begin
			pending = stat & ~mask;
		end
	endfunction

	function automatic logic line_enabled(input logic [7:0] cfg);
		// the line stays released until software turns it on
		line_enabled = cfg[`BIT_IRQ_EN];
	endfunction

	function automatic logic addr_taken(input logic sel, input logic rdy, input logic [1:0] trans);
		// idle and busy cycles carry no transfer
		addr_taken = sel && rdy && trans[1];
	endfunction

	function automatic logic [7:0] reg_index(input logic [31:0] addr);
		// one register per aligned word
		reg_index = addr[9:2];
	endfunction

	event_reg_bank u_bank (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.rd_index_i(nxt_st.idx),
		.regs_i(st_ff.regs),
		.temp_code_i(temp_code_i),
		.rd_data_o(rd_data)
	);

	always_comb begin
		logic [7:0] set09;
		logic [7:0] set0a;
		logic [7:0] clr11;
		logic [7:0] clr12;
		logic [7:0] open09;
		logic [7:0] open0a;
		logic [7:0] pend;
		logic wr_now;
		logic warn_now;
		logic crit_now;
		logic pass_masked;
		logic line_on;
		logic irq_want;
		set09 = 8'h00;
		set0a = 8'h00;
		clr11 = 8'h00;
		clr12 = 8'h00;
		open09 = 8'h00;
		open0a = 8'h00;
		pend = 8'h00;
		wr_now = 1'b0;
		warn_now = 1'b0;
		crit_now = 1'b0;
		pass_masked = 1'b0;
		line_on = 1'b0;
		irq_want = 1'b0;
		nxt_st = st_ff;

		// event capture
		warn_now = at_or_above(temp_code_i, st_ff.regs.tcfg1b[2:0]);
		crit_now = at_or_above(temp_code_i, st_ff.regs.crit2e[2:0]);
		// level conditions re-set their bit each cycle, so a clear while present does not stick
		set09[`BIT_BUCKC_HI] = buck_c_high_current_i;
		set09[`BIT_TEMP_WARN] = warn_now;
		set0a[`BIT_PEC] = pec_error_i;
		set0a[`BIT_PARITY] = parity_error_i;

		// writes land at the end of the data phase
		wr_now = st_ff.phase == status_event_pkg::PH_DATA && st_ff.wr;
		if (wr_now) begin
			unique case (st_ff.idx)
				`REG_CLR11: clr11 = hwdata[7:0];
				`REG_CLR12: clr12 = hwdata[7:0];
				`REG_MASK16: nxt_st.regs.mask16 = hwdata[7:0];
				`REG_MASK17: nxt_st.regs.mask17 = hwdata[7:0];
				`REG_TCFG1B: nxt_st.regs.tcfg1b = hwdata[7:0];
				`REG_CRIT2E: nxt_st.regs.crit2e = hwdata[7:0];
				`REG_MCFG2F: nxt_st.regs.mcfg2f = hwdata[7:0];
				default: nxt_st.regs.mcfg2f = st_ff.regs.mcfg2f;
			endcase
		end

		// status flags
		nxt_st.regs.st09 = sticky(st_ff.regs.st09, set09, clr11);
		nxt_st.regs.st0a = sticky(st_ff.regs.st0a, set0a, clr12);
		// no clear path: critical stays latched until rst_i
		nxt_st.regs.crit = st_ff.regs.crit | crit_now;

		// line and rails
		// masked events only reach the line when 0x2F[1:0] selects it
		pass_masked = masked_reach_line(st_ff.regs.mcfg2f[1:0]);
		open09 = pending(st_ff.regs.st09, st_ff.regs.mask16, pass_masked);
		open0a = pending(st_ff.regs.st0a, st_ff.regs.mask17, pass_masked);
		pend = open09 | open0a;
		irq_want = (|pend) || st_ff.regs.crit;
		line_on = line_enabled(st_ff.regs.tcfg1b);
		nxt_st.irq_oe = irq_want && line_on;
		nxt_st.rails_ok = !st_ff.regs.crit;
		nxt_st.shut = st_ff.regs.crit;
		// zero-wait slave, always okay; the pin data never leaves low
		nxt_st.ready = 1'b1;
		nxt_st.err = 1'b0;
		nxt_st.pin = 1'b0;

		// address phase
		nxt_st.phase = status_event_pkg::PH_IDLE;
		if (addr_taken(hsel, hready, htrans)) begin
			nxt_st.phase = status_event_pkg::PH_DATA;
			nxt_st.wr = hwrite;
			nxt_st.idx = reg_index(haddr);
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff.regs.st09 <= 8'h00;
			st_ff.regs.st0a <= 8'h00;
			st_ff.regs.crit <= 1'b0;

			st_ff.regs.mask16 <= `RST_MASK;
			st_ff.regs.mask17 <= `RST_MASK;
			st_ff.regs.tcfg1b <= `RST_TCFG1B;
			st_ff.regs.crit2e <= `RST_CRIT2E;
			st_ff.regs.mcfg2f <= `RST_MCFG2F;

			st_ff.phase <= status_event_pkg::PH_IDLE;
			st_ff.wr <= 1'b0;
			st_ff.idx <= 8'h00;

			st_ff.irq_oe <= 1'b0;
			st_ff.rails_ok <= 1'b1;
			st_ff.shut <= 1'b0;
			st_ff.ready <= 1'b1;
			st_ff.err <= 1'b0;
			st_ff.pin <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hrdata = rd_data;
	assign hreadyout = st_ff.ready;
	assign hresp = st_ff.err;
	// open drain: output data held low, only the enable moves
	assign general_status_irq_line_o = st_ff.pin;
	assign general_status_irq_line_oe_o = st_ff.irq_oe;
	assign rails_ok_output_o = st_ff.rails_ok;
	assign regulator_shutdown_request_o = st_ff.shut;
endmodule // status_event_interrupt_logic

// ==== pkg/status_event_defs.svh ====
`ifndef STATUS_EVENT_DEFS_SVH
`define STATUS_EVENT_DEFS_SVH
// register indices as printed; byte address is four times the index
`define REG_STAT08 8'h08
`define REG_STAT09 8'h09
`define REG_STAT0A 8'h0A
`define REG_CLR11 8'h11
`define REG_CLR12 8'h12
`define REG_MASK16 8'h16
`define REG_MASK17 8'h17
`define REG_TCFG1B 8'h1B
`define REG_CRIT2E 8'h2E
`define REG_MCFG2F 8'h2F
`define REG_TEMP_NOW 8'h40
`define BIT_CRIT 6
`define BIT_BUCKC_HI 0
`define BIT_TEMP_WARN 7
`define BIT_PEC 3
`define BIT_PARITY 2
`define BIT_IRQ_EN 3
`define RST_TCFG1B 8'h00
`define RST_CRIT2E 8'h07
`define RST_MASK 8'h00
`define RST_MCFG2F 8'h00
`endif

// ==== pkg/status_event_pkg.sv ====
package status_event_pkg;
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_DATA
	} bus_phase_t;
	typedef struct packed {
		logic [7:0] st09;
		logic [7:0] st0a;
		logic crit;
		logic [7:0] mask16;
		logic [7:0] mask17;
		logic [7:0] tcfg1b;
		logic [7:0] crit2e;
		logic [7:0] mcfg2f;
	} event_regs_t;
endpackage

// ==== verif/host_model.sv ====
`timescale 1ns/1ps
module host_model (
	input wire logic clk_sys_i,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	output logic [31:0] rdata_o,
	output logic rv_o
);
	initial {haddr, htrans, hwrite, hwdata, rdata_o, rv_o} = '0;
	initial hsize = 3'h2;
	// reads find the cause, writes clear or mask it
	task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
		haddr <= {22'h0, i, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys_i); while (!hready);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk_sys_i); while (!hready);
		// read data is taken at the edge that ends the data phase
		rdata_o <= hrdata;
		hwdata <= ~hwdata;
		rv_o <= !w;
		@(posedge clk_sys_i);
		rv_o <= 1'b0;
	endtask
endmodule // host_model

// ==== verif/status_event_chk.sv ====
`timescale 1ns/1ps
module status_event_chk (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [2:0] temp_code_i,
	input wire logic general_status_irq_line_o,
	input wire logic general_status_irq_line_oe_o,
	input wire logic rails_ok_output_o,
	input wire logic regulator_shutdown_request_o
);
	wire oe = general_status_irq_line_oe_o;
	wire ok = rails_ok_output_o;
	logic [2:0] age_ff;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// cycles since a write; an irq release needs a recent one
	always_ff @(posedge clk_sys_i or posedge rst_i)
		if (rst_i) age_ff <= 3'h7;
		else age_ff <= (htrans[1] && hwrite) ? 3'h0 : age_ff + 3'(age_ff != 3'h7);
	property p_pin; general_status_irq_line_o == 1'b0; endproperty
	a_pin: assert property (p_pin) else $error("pin high");
	property p_rdy; hreadyout; endproperty
	a_rdy: assert property (p_rdy) else $error("wait state");
	property p_okay; !hresp; endproperty
	a_okay: assert property (p_okay) else $error("error resp");
	property p_sd; regulator_shutdown_request_o == !ok; endproperty
	a_sd: assert property (p_sd) else $error("shutdown vs rails");
	property p_stick; !ok |=> !ok; endproperty
	a_stick: assert property (p_stick) else $error("rails back");
	property p_crit; $fell(ok) |-> $past(temp_code_i, 2) == 3'h7; endproperty
	a_crit: assert property (p_crit) else $error("rails fell");
	property p_en; $fell(rst_i) |-> !oe [*2]; endproperty
	a_en: assert property (p_en) else $error("irq at reset");
	property p_hold; $fell(oe) |-> age_ff <= 3'h4; endproperty
	a_hold: assert property (p_hold) else $error("irq dropped");
	cover property ($rose(oe));
	cover property ($fell(ok));
	cover property ($fell(oe));
endmodule // status_event_chk
bind status_event_interrupt_logic status_event_chk u_chk (.clk_sys_i, .rst_i, .htrans, .hwrite, .hreadyout, .hresp,
	.temp_code_i, .general_status_irq_line_o, .general_status_irq_line_oe_o, .rails_ok_output_o,
	.regulator_shutdown_request_o);

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic clk_sys_i = 0, rst_i = 1, hsel = 1, buck = 0, pec = 0, par = 0;
	logic [2:0] temp = 0;
	logic [31:0] haddr, hwdata, hrdata, rdata;
	logic [31:0] sbit = 32'h04088001;
	logic [2:0] hsize;
	logic [1:0] htrans;
	logic hwrite, hready, hresp, rv, oe, ok;
	logic [9:0] q[$];
	int n_errors = 0;
	int checked = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	status_event_interrupt_logic u_dut (.clk_sys_i, .rst_i, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel, .hready,
		.hrdata, .hreadyout(hready), .hresp, .buck_c_high_current_i(buck), .temp_code_i(temp), .pec_error_i(pec),
		.parity_error_i(par), .general_status_irq_line_o(), .general_status_irq_line_oe_o(oe), .rails_ok_output_o(ok),
		.regulator_shutdown_request_o());
	host_model u_host (.clk_sys_i, .hready, .hrdata, .haddr, .htrans, .hwrite, .hsize, .hwdata, .rdata_o(rdata),
		.rv_o(rv));
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR rails_irq_data exp %h seen %h", exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// oldest note pairs with the read that just finished
	always @(posedge clk_sys_i) if (rv) check({ok, oe, rdata[7:0]}, q.pop_front());
	task automatic rd(input logic [7:0] i, input logic [9:0] e);
		q.push_back(e);
		u_host.xfer(1'b0, i, 8'h00);
	endtask
	task automatic ev(input int k, input logic v);
		{par, pec, buck} <= {v && k == 3, v && k == 2, v && k == 0};
		temp <= (v && k == 1) ? 3'h5 + 3'($urandom % 2) : 3'($urandom % 5);
		repeat (3) @(posedge clk_sys_i);
	endtask
	initial begin
		void'($urandom(32'h495A));
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd(8'h1B, 10'h200);
		// threshold code 0 warns at any temperature: raise it and clear before the line goes on
		u_host.xfer(1'b1, 8'h1B, 8'h05);
		u_host.xfer(1'b1, 8'h11, 8'hFF);
		u_host.xfer(1'b1, 8'h1B, 8'h0D);
		rd(8'h30, 10'h200);
		$display("reset test done");
		for (int k = 0; k < 4; k++) begin
			ev(k, 1'b1);
			ev(k, 1'b0);
			rd(8'h09 + 8'(k / 2), {2'b11, sbit[8*k+:8]});
			u_host.xfer(1'b1, 8'h11 + 8'(k / 2), sbit[8*k+:8]);
			rd(8'h09 + 8'(k / 2), 10'h200);
		end
		ev(0, 1'b1);
		u_host.xfer(1'b1, 8'h11, 8'h01);
		rd(8'h09, 10'h301);
		ev(0, 1'b0);
		u_host.xfer(1'b1, 8'h11, 8'h01);
		ev(2, 1'b1);
		rd(8'h0A, 10'h308);
		u_host.xfer(1'b1, 8'h17, 8'h08);
		rd(8'h0A, 10'h208);
		u_host.xfer(1'b1, 8'h2F, 8'h01);
		rd(8'h0A, 10'h308);
		u_host.xfer(1'b1, 8'h2F, 8'h00);
		rd(8'h0A, 10'h208);
		$display("event test done");
		temp <= 3'h7;
		repeat (3) @(posedge clk_sys_i);
		rd(8'h08, 10'h140);
		$display("critical test done");
		@(posedge clk_sys_i);
		final_report();
	end
	initial begin
		#20000; // the sequence needs well under a thousand cycles
		n_errors++;
		final_report();
	end
endmodule // testbench
